// ==== slli_host_model.sv ====
`timescale 1ns/10ps
// ==========================================
// host controller on the serial pins
module slli_host_model (
    // clock
    input wire ref_clk,
    // serial pins
    output reg serial_clk,
    output reg serial_data,
    output reg load_strobe
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // slow phases leave room for the two-flop sync
    task automatic send_word(input logic [31:0] w);
        integer i;
        for (i = 31; i >= 0; i--) begin
            serial_data <= w[i];
            repeat (4) @(posedge ref_clk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            serial_clk <= 1'b0;
        end
        // released line shows inverse of last bit
        serial_data <= ~w[0];
        repeat (4) @(posedge ref_clk);
        load_strobe <= 1'b1;
        repeat (8) @(posedge ref_clk);
        load_strobe <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// ==== slli_map.vh ====
`ifndef SLLI_MAP_VH
`define SLLI_MAP_VH

// =====================================================================
// word geometry
`define SLLI_WORD_W          32
`define SLLI_SEL_W           3
`define SLLI_SEL_MSB         2
`define SLLI_SEL_LSB         0

// =====================================================================
// latch select codes
`define SLLI_SEL_INT_FRAC    3'h0
`define SLLI_SEL_LSB_FRAC    3'h1
`define SLLI_SEL_REF_DIV     3'h2
`define SLLI_AUX_FIRST       3
`define SLLI_AUX_COUNT       5

// =====================================================================
// integer_and_msb_fraction fields
`define SLLI_R0_RAMP_BIT     31
`define SLLI_R0_MUX_MSB      30
`define SLLI_R0_MUX_LSB      27
`define SLLI_R0_INT_MSB      26
`define SLLI_R0_INT_LSB      15
`define SLLI_R0_FRAC_MSB     14
`define SLLI_R0_FRAC_LSB     3

// =====================================================================
// lsb_fraction fields
`define SLLI_R1_FRAC_MSB     27
`define SLLI_R1_FRAC_LSB     15

// =====================================================================
// reference_divider_config fields
`define SLLI_R2_CSR_BIT      28
`define SLLI_R2_CPI_MSB      27
`define SLLI_R2_CPI_LSB      24
`define SLLI_R2_PRESC_BIT    22
`define SLLI_R2_HALF_BIT     21
`define SLLI_R2_DBL_BIT      20
`define SLLI_R2_RCNT_MSB     19
`define SLLI_R2_RCNT_LSB     15
`define SLLI_R2_CLK1_MSB     14
`define SLLI_R2_CLK1_LSB     3

// =====================================================================
// output multiplexer codes
`define SLLI_MUX_TRISTATE    4'h0
`define SLLI_MUX_HIGH        4'h1
`define SLLI_MUX_LOW         4'h2
`define SLLI_MUX_REF_DIV     4'h3
`define SLLI_MUX_LOADED      4'h4

// =====================================================================
// reset values
`define SLLI_RST_WORD        32'h00000000
`define SLLI_RST_RCNT        5'h01

`endif

// ==== slli_serial_load.v ====
`timescale 1ns/10ps
`include "slli_map.vh"

// Overview of operation
// R1 - each serial clock rising edge shifts one data bit into the 32-bit register
// R2 - words arrive most significant bit first; first bit ends at bit 31
// R3 - load strobe rising edge copies the shift register into one of eight latches
// R4 - three lowest shifted bits pick the latch and are not payload; latches 3 to 7 still keep them in the whole word
// R5 - select value 0 to 7 addresses the latch of the same index
// R6 - buffered settings stay at old value until a later R0 load
// R7 - buffered: low fraction, reference count, doubler, pump current, halving bit
// R8 - host writes R1 before R0; frequency change starts at R0 load
// R9 - R0 bits 30 to 27 choose what drives the multiplexed output pin
// R10 - device holds 5-bit reference, 12-bit integer and 25-bit fraction values
// R11 - R0 holds ramp enable bit 31, integer 26:15, upper fraction 14:3
// R12 - R1 holds lower 13 fraction bits 27:15; other bits reserved zero
// R13 - host only programs integer values from 23 to 4095
// R14 - reference counter divides reference input by 1 to 32
// R15 - R2 holds slip reduction, pump current, prescaler, halving, doubler, count, divider
// R16 - loads to latches other than R0 update unbuffered fields at once
module slli_serial_load (
    // clock and reset
    input  wire                          ref_clk,
    input  wire                          reset_n,
    // serial pins
    input  wire                          serial_clk,
    input  wire                          serial_data,
    input  wire                          load_strobe,
    // reference input pin
    input  wire                          ref_in,
    // integer_and_msb_fraction settings
    output reg                           ramp_enable,
    output reg  [3:0]                    outsel,
    output reg  [11:0]                   int_value,
    output reg  [24:0]                   frac_value,
    output reg                           freq_change_start,
    // reference_divider_config settings
    output reg                           cycle_slip_reduction_enable,
    output reg  [3:0]                    pump_current_field,
    output reg                           prescaler_select,
    output reg                           reference_halving_bit,
    output reg                           ref_doubler,
    output reg  [4:0]                    ref_count,
    output reg  [11:0]                   ramp_clk_divider,
    // remaining latches, index 3 in the low word
    output wire [5*`SLLI_WORD_W-1:0]     aux_latches,
    // reference counter output
    output reg                           pfd_ref_tick,
    // multiplexed output pin
    output reg                           multiplexed_output_pin,
    output reg                           multiplexed_output_oe_n
);

    // =================================================================
    // pin synchronisers
    reg  [1:0]                  sclk_sync_q;
    reg  [1:0]                  sdat_sync_q;
    reg  [1:0]                  le_sync_q;
    reg  [1:0]                  ref_sync_q;
    reg                         sclk_prev_q;
    reg                         le_prev_q;
    reg                         ref_prev_q;
    wire                        sclk_rise;
    wire                        le_rise;
    wire                        ref_rise;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync_q <= 2'h0;
            sdat_sync_q <= 2'h0;
            le_sync_q   <= 2'h0;
            ref_sync_q  <= 2'h0;
            sclk_prev_q <= 1'b0;
            le_prev_q   <= 1'b0;
            ref_prev_q  <= 1'b0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], serial_clk};
            sdat_sync_q <= {sdat_sync_q[0], serial_data};
            le_sync_q   <= {le_sync_q[0], load_strobe};
            ref_sync_q  <= {ref_sync_q[0], ref_in};
            sclk_prev_q <= sclk_sync_q[1];
            le_prev_q   <= le_sync_q[1];
            ref_prev_q  <= ref_sync_q[1];
        end
    end

    // edges seen only on the second stage, never the first
    assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
    assign le_rise   = le_sync_q[1] & ~le_prev_q;
    assign ref_rise  = ref_sync_q[1] & ~ref_prev_q;

    // =================================================================
    // shift register
    // serial clock must stay below a quarter of ref_clk for clean edges
    reg  [`SLLI_WORD_W-1:0]     shift_q;
    wire [`SLLI_SEL_W-1:0]      sel;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= `SLLI_RST_WORD;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[`SLLI_WORD_W-2:0], sdat_sync_q[1]}; // R1 R2
        end
    end

    assign sel = shift_q[`SLLI_SEL_MSB:`SLLI_SEL_LSB]; // R4

    // =================================================================
    // pending copies of the buffered settings
    reg  [12:0]                 frac_lsb_pend_q;
    reg  [3:0]                  cpi_pend_q;
    reg                         half_pend_q;
    reg                         dbl_pend_q;
    reg  [4:0]                  rcnt_pend_q;
    wire                        load_r0;
    wire                        load_r1;
    wire                        load_r2;

    assign load_r0 = le_rise & (sel == `SLLI_SEL_INT_FRAC); // R5
    assign load_r1 = le_rise & (sel == `SLLI_SEL_LSB_FRAC); // R5
    assign load_r2 = le_rise & (sel == `SLLI_SEL_REF_DIV);  // R5

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frac_lsb_pend_q <= 13'h0000;
            cpi_pend_q      <= 4'h0;
            half_pend_q     <= 1'b0;
            dbl_pend_q      <= 1'b0;
            rcnt_pend_q     <= `SLLI_RST_RCNT;
        end else begin
            if (load_r1) begin
                frac_lsb_pend_q <= shift_q[`SLLI_R1_FRAC_MSB:`SLLI_R1_FRAC_LSB]; // R12 R7
            end
            if (load_r2) begin
                cpi_pend_q  <= shift_q[`SLLI_R2_CPI_MSB:`SLLI_R2_CPI_LSB];   // R7
                half_pend_q <= shift_q[`SLLI_R2_HALF_BIT];                   // R7
                dbl_pend_q  <= shift_q[`SLLI_R2_DBL_BIT];                    // R7
                rcnt_pend_q <= shift_q[`SLLI_R2_RCNT_MSB:`SLLI_R2_RCNT_LSB]; // R7
            end
        end
    end

    // =================================================================
    // active settings
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ramp_enable                 <= 1'b0;
            outsel                      <= `SLLI_MUX_TRISTATE;
            int_value                   <= 12'h000;
            frac_value                  <= 25'h0000000;
            freq_change_start           <= 1'b0;
            cycle_slip_reduction_enable <= 1'b0;
            pump_current_field          <= 4'h0;
            prescaler_select            <= 1'b0;
            reference_halving_bit       <= 1'b0;
            ref_doubler                 <= 1'b0;
            ref_count                   <= `SLLI_RST_RCNT;
            ramp_clk_divider            <= 12'h000;
        end else begin
            freq_change_start <= load_r0; // R8
            if (load_r0) begin
                ramp_enable <= shift_q[`SLLI_R0_RAMP_BIT];                 // R11
                outsel      <= shift_q[`SLLI_R0_MUX_MSB:`SLLI_R0_MUX_LSB]; // R9
                int_value   <= shift_q[`SLLI_R0_INT_MSB:`SLLI_R0_INT_LSB]; // R11 R10
                // lower fraction takes its pending copy only now
                frac_value  <= {shift_q[`SLLI_R0_FRAC_MSB:`SLLI_R0_FRAC_LSB],
                                frac_lsb_pend_q};                          // R6 R10
                pump_current_field    <= cpi_pend_q;                       // R6
                reference_halving_bit <= half_pend_q;                      // R6
                ref_doubler           <= dbl_pend_q;                       // R6
                ref_count             <= rcnt_pend_q;                      // R6 R10
            end
            if (load_r2) begin
                cycle_slip_reduction_enable <= shift_q[`SLLI_R2_CSR_BIT];  // R15 R16
                prescaler_select            <= shift_q[`SLLI_R2_PRESC_BIT]; // R15 R16
                ramp_clk_divider <= shift_q[`SLLI_R2_CLK1_MSB:`SLLI_R2_CLK1_LSB]; // R15 R16
            end
        end
    end

    // =================================================================
    // remaining latches, whole word kept
    genvar g;
    generate
        for (g = 0; g < `SLLI_AUX_COUNT; g = g + 1) begin : aux
            reg [`SLLI_WORD_W-1:0] word_q;
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    word_q <= `SLLI_RST_WORD;
                end else if (le_rise && (sel == (g + `SLLI_AUX_FIRST))) begin
                    word_q <= shift_q; // R3 R16
                end
            end
            assign aux_latches[g*`SLLI_WORD_W +: `SLLI_WORD_W] = word_q;
        end
    endgenerate

    // =================================================================
    // reference counter; count 0 stands for 32
    reg  [5:0]                  ref_cnt_q;
    reg                         ref_div_q;
    reg                         loaded_q;
    wire [5:0]                  ref_ratio;

    assign ref_ratio = (ref_count == 5'h00) ? 6'h20 : {1'b0, ref_count};

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_cnt_q    <= 6'h01;
            ref_div_q    <= 1'b0;
            pfd_ref_tick <= 1'b0;
        end else begin
            pfd_ref_tick <= 1'b0;
            if (ref_rise) begin
                if (ref_cnt_q >= ref_ratio) begin
                    ref_cnt_q    <= 6'h01;
                    pfd_ref_tick <= 1'b1;  // R14
                    ref_div_q    <= ~ref_div_q;
                end else begin
                    ref_cnt_q <= ref_cnt_q + 6'h01; // R14
                end
            end
        end
    end

    // =================================================================
    // output multiplexer
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            loaded_q                <= 1'b0;
            multiplexed_output_pin  <= 1'b0;
            multiplexed_output_oe_n <= 1'b1;
        end else begin
            if (load_r0) begin
                loaded_q <= 1'b1;
            end
            multiplexed_output_oe_n <= (outsel == `SLLI_MUX_TRISTATE); // R9
            case (outsel)
                `SLLI_MUX_HIGH:    multiplexed_output_pin <= 1'b1;      // R9
                `SLLI_MUX_REF_DIV: multiplexed_output_pin <= ref_div_q; // R9
                `SLLI_MUX_LOADED:  multiplexed_output_pin <= loaded_q;  // R9
                default:           multiplexed_output_pin <= 1'b0;
            endcase
        end
    end

endmodule

// ==== slli_serial_load_asserts.sv ====
`timescale 1ns/10ps
// ==========================================
// serial load checker
module slli_sl_asserts (
    // clock and reset
    input wire        ref_clk,
    input wire        reset_n,
    // serial pins
    input wire        load_strobe,
    // settings
    input wire [3:0]  outsel,
    input wire [11:0] int_value,
    input wire [24:0] frac_value,
    input wire        freq_change_start,
    input wire [3:0]  pump_current_field,
    input wire [4:0]  ref_count,
    input wire [11:0] ramp_clk_divider,
    // pulses and pin
    input wire        pfd_ref_tick,
    input wire        multiplexed_output_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    start_pulse_a: assert property (freq_change_start |=> !freq_change_start)
        else $error("start pulse longer than one cycle");
    tick_pulse_a: assert property (pfd_ref_tick |=> !pfd_ref_tick)
        else $error("reference tick longer than one cycle");
    start_cause_a: assert property (freq_change_start |-> $past(load_strobe, 3))
        else $error("start pulse without load");
    int_hold_a: assert property ($changed(int_value) |-> freq_change_start)
        else $error("integer changed outside load");
    frac_hold_a: assert property ($changed(frac_value) |-> freq_change_start)
        else $error("fraction changed outside load");
    rcnt_hold_a: assert property ($changed(ref_count) |-> freq_change_start)
        else $error("reference count changed outside load");
    pump_hold_a: assert property ($changed(pump_current_field) |-> freq_change_start)
        else $error("pump current changed outside load");
    mux_oe_a: assert property (1'b1 |=> multiplexed_output_oe_n == ($past(outsel) == 4'h0))
        else $error("output enable does not follow select");
    div_load_a: assert property ($changed(ramp_clk_divider) |-> $past(load_strobe, 2))
        else $error("divider changed without load");
    cover property (freq_change_start);
    cover property (pfd_ref_tick);
    cover property ($changed(ramp_clk_divider));
endmodule

bind slli_serial_load slli_sl_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .load_strobe(load_strobe), .outsel(outsel), .int_value(int_value),
    .frac_value(frac_value), .freq_change_start(freq_change_start),
    .pump_current_field(pump_current_field), .ref_count(ref_count),
    .ramp_clk_divider(ramp_clk_divider), .pfd_ref_tick(pfd_ref_tick),
    .multiplexed_output_oe_n(multiplexed_output_oe_n));

// ==== slli_serial_load_tb.sv ====
`timescale 1ns/10ps
module slli_serial_load_tb;
    reg ref_clk = 1'b0;
    reg reset_n = 1'b0;
    reg ref_in = 1'b0;
    reg [3:0] ph = 4'h0;
    reg [31:0] w;
    integer error_cnt = 0;
    integer n_checks = 0;
    integer i;
    integer n;
    wire serial_clk, serial_data, load_strobe, ramp_enable, freq_change_start, cyc_slip;
    wire presc, halving, doubler, pfd_ref_tick, mux_pin, mux_oe_n;
    wire [3:0] outsel, pump;
    wire [11:0] int_value, div;
    wire [24:0] frac_value;
    wire [4:0] ref_count;
    wire [159:0] aux;
    // ==========================================
    // clock, reference input, instances
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        ph <= ph + 4'h1;
        if (ph[1:0] == 2'h3) ref_in <= ~ref_in;
    end
    slli_host_model host (.ref_clk(ref_clk), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe));
    slli_serial_load dut (.ref_clk(ref_clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe), .ref_in(ref_in),
        .ramp_enable(ramp_enable), .outsel(outsel), .int_value(int_value),
        .frac_value(frac_value), .freq_change_start(freq_change_start),
        .cycle_slip_reduction_enable(cyc_slip), .pump_current_field(pump),
        .prescaler_select(presc), .reference_halving_bit(halving), .ref_doubler(doubler),
        .ref_count(ref_count), .ramp_clk_divider(div), .aux_latches(aux),
        .pfd_ref_tick(pfd_ref_tick), .multiplexed_output_pin(mux_pin),
        .multiplexed_output_oe_n(mux_oe_n));
    // ==========================================
    // checking and closing
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wait_tick;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pfd_ref_tick !== 1'b1 && n < 300);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_sim;
    end
    // ==========================================
    // tests
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("ref_count", 32'h1, ref_count);
        host.send_word({4'h0, 13'h1ABC, 12'h000, 3'h1});
        chk("frac_value", 32'h0, frac_value);
        host.send_word({3'h0, 1'b1, 4'hA, 1'b0, 1'b1, 1'b1, 1'b1, 5'h03, 12'h5A5, 3'h2});
        chk("ramp_clk_divider", 32'h5A5, div);
        chk("slip_and_prescaler", 32'h3, {cyc_slip, presc});
        chk("pump_current", 32'h0, pump);
        chk("ref_count", 32'h1, ref_count);
        chk("halving_doubler", 32'h0, {halving, doubler});
        host.send_word({1'b1, 4'h1, 12'd100, 12'hC35, 3'h0});
        chk("int_value", 32'd100, int_value);
        chk("frac_value", {7'h0, 12'hC35, 13'h1ABC}, frac_value);
        chk("ramp_enable", 32'h1, ramp_enable);
        chk("pump_current", 32'hA, pump);
        chk("ref_count", 32'h3, ref_count);
        chk("halving_doubler", 32'h3, {halving, doubler});
        chk("mux_high", 32'h1, {mux_oe_n, mux_pin});
        host.send_word({1'b0, 4'h2, 12'd4095, 12'h000, 3'h0});
        chk("mux_low", 32'h0, {mux_oe_n, mux_pin});
        chk("frac_value", {7'h0, 12'h000, 13'h1ABC}, frac_value);
        host.send_word({1'b0, 4'h4, 12'd4095, 12'h000, 3'h0});
        chk("mux_loaded", 32'h1, {mux_oe_n, mux_pin});
        host.send_word({1'b0, 4'h0, 12'd4095, 12'h000, 3'h0});
        chk("mux_tristate", 32'h1, mux_oe_n);
        for (i = 3; i < 8; i++) begin
            w = {8'hC0 + i[7:0], 21'h0, i[2:0]};
            host.send_word(w);
            chk("aux_latch", w, aux[32*(i-3) +: 32]);
        end
        chk("int_value", 32'd4095, int_value);
        wait_tick;
        wait_tick;
        chk("tick_period", 32'd24, n);
        end_sim;
    end
endmodule
